// *** hdl/pdsc_defs.svh ***
// pdsc_defs.svh: offsets, field positions, reset values and constants of the PLL/divider source config block.
// assumes inclusion by bare name from every design file that needs it.
`ifndef PDSC_DEFS_SVH
`define PDSC_DEFS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define PDSC_OFS_SEC_SRC     8'h33
`define PDSC_OFS_NM_SRC      8'h34
`define PDSC_OFS_PRESCALE    8'h35
`define PDSC_OFS_MULT_HIGH   8'h36
`define PDSC_OFS_FRAC_LOW    8'h37

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PDSC_RST_SEC_SRC     8'h00
`define PDSC_RST_NM_SRC      8'h10
`define PDSC_RST_PRESCALE    8'h01
`define PDSC_RST_MULT_HIGH   8'h00
`define PDSC_RST_FRAC_LOW    8'h00

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PDSC_SEC_SRC_HI      6
`define PDSC_SEC_SRC_LO      4
`define PDSC_DIG_NM_HI       7
`define PDSC_DIG_NM_LO       6
`define PDSC_ANA_NM_HI       5
`define PDSC_ANA_NM_LO       4
`define PDSC_JMUL_TOP_BIT    7
`define PDSC_HALVE_BIT       6
`define PDSC_FRAC_TOP_HI     5
`define PDSC_FRAC_TOP_LO     0
// writable bits of the secondary source register; others read zero
`define PDSC_SEC_SRC_WMASK   8'h70

// ----------------------------------------------------------------
// arithmetic constants
// ----------------------------------------------------------------
`define PDSC_PRESCALE_ZERO   9'h100
`define PDSC_FRAC_SCALE      10000
`define PDSC_FRAC_MAX        14'h270F
`define PDSC_SEC_SRC_VALID   8'h3B

`endif

// *** hdl/pdsc_pkg.sv ***
// pdsc_pkg: types shared by the PLL/divider source config block.
// assumes nothing beyond a SystemVerilog compiler.
package pdsc_pkg;

	// ----------------------------------------------------------------
	// effective PLL settings
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [8:0]  p_div;
		logic [8:0]  j_mult;
		logic [13:0] d_frac;
		logic        halve;
	} pdsc_pll_cfg_t;

	// ----------------------------------------------------------------
	// programmed source selections
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [2:0] second_port_bitdiv_source;
		logic [1:0] digital_nm_source;
		logic [1:0] analog_nm_source;
	} pdsc_src_sel_t;

	typedef enum logic [1:0] {
		PDSC_ST_IDLE,
		PDSC_ST_MUL,
		PDSC_ST_DIV,
		PDSC_ST_DONE
	} pdsc_state_t;

endpackage

// *** hdl/pdsc_sync.sv ***
// pdsc_sync: two flip-flop synchroniser for a vector of independent levels.
// assumes each bit is an unrelated asynchronous level.
`timescale 1ns/100ps
`default_nettype none

module pdsc_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] meta_reg;

	// first stage is read only by the second stage
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end

endmodule

`default_nettype wire

// *** hdl/pdsc_src_mux.sv ***
// pdsc_src_mux: registered source selector with a per-code legality mask.
// assumes sampled, same-clock source levels; reserved codes park the output low.
`timescale 1ns/100ps
`default_nettype none

module pdsc_src_mux #(
	parameter int              SW    = 2,
	parameter logic [2**SW-1:0] VALID = '1
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [2**SW-1:0] src,
	input  wire logic [SW-1:0]    sel,
	output logic                  out_reg,
	output logic                  reserved_reg
);

	// parking low avoids passing an undefined source to the divider
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			out_reg      <= 1'b0;
			reserved_reg <= 1'b0;
		end else begin
			out_reg      <= VALID[sel] & src[sel];
			reserved_reg <= ~VALID[sel];
		end
	end

endmodule

`default_nettype wire

// *** hdl/pdsc_top.sv ***
// pdsc_top: clock source selection and PLL P/J/D configuration registers with output frequency engine.
// assumes a same-clock control-port register strobe interface; clock sources arrive as asynchronous pins.
// Functional notes
// RULE1: secondary bit divider source codes, 2/6/7 reserved
// RULE2: digital nm source: primary, secondary, control, oscillator
// RULE3: analog nm source: pll, pll, digital, primary
// RULE4: prescale code zero means 256, reset one
// RULE5: auto detection overrides programmed P, J, D
// RULE6: bit 7 is integer multiplier top bit
// RULE7: bit 6 halves the PLL divider clock
// RULE8: fraction is six top bits plus low byte
// RULE9: software keeps fraction within 0 to 9999
// RULE10: software writes reset value to reserved bits
// RULE11: integer multiplier 1 to 511, zero reserved
// RULE12: output equals input over P times J+D/10000
`timescale 1ns/100ps
`default_nettype none
`include "pdsc_defs.svh"

module pdsc_top
	import pdsc_pkg::*;
#(
	parameter int FW = 28,
	parameter int OW = 32
) (
	input  wire logic          clk,
	input  wire logic          rst,
	// control-port register access
	input  wire logic          reg_wr,
	input  wire logic          reg_rd,
	input  wire logic [7:0]    reg_addr,
	input  wire logic [7:0]    reg_wdata,
	output logic      [7:0]    reg_rdata,
	output logic               reg_rvalid,
	output logic               reg_hit,
	// integer multiplier low byte held in a neighbouring register
	input  wire logic [7:0]    pll_integer_mult_low,
	// auto detection override
	input  wire logic          auto_detect_en,
	input  wire pdsc_pll_cfg_t auto_cfg,
	// clock source pins
	input  wire logic          pll_out_clk,
	input  wire logic          primary_bitclk,
	input  wire logic          secondary_bitclk,
	input  wire logic          control_port_clock,
	input  wire logic          osc_clk,
	input  wire logic          dsp_clk,
	// measured frequency of the PLL input
	input  wire logic [FW-1:0] ref_freq_hz,
	// results
	output pdsc_src_sel_t      src_sel,
	output pdsc_pll_cfg_t      pll_cfg,
	output logic               second_port_bitdiv_clk,
	output logic               digital_nm_clk,
	output logic               analog_nm_clk,
	output logic               second_port_src_reserved,
	output logic               cfg_error,
	output logic      [OW-1:0] pll_freq_hz,
	output logic               freq_valid
);

	localparam int MW = 23;
	localparam int DW = 22;
	localparam int NW = FW + MW;
	localparam int CW = 6;

	// ----------------------------------------------------------------
	// register file
	// ----------------------------------------------------------------
	logic [7:0] sec_src_reg;
	logic [7:0] nm_src_reg;
	logic [7:0] prescale_reg;
	logic [7:0] mult_high_reg;
	logic [7:0] frac_low_reg;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sec_src_reg   <= `PDSC_RST_SEC_SRC;
			nm_src_reg    <= `PDSC_RST_NM_SRC;
			prescale_reg  <= `PDSC_RST_PRESCALE;
			mult_high_reg <= `PDSC_RST_MULT_HIGH;
			frac_low_reg  <= `PDSC_RST_FRAC_LOW;
		end else if (reg_wr) begin
			unique case (reg_addr)
				`PDSC_OFS_SEC_SRC:   sec_src_reg   <= reg_wdata & `PDSC_SEC_SRC_WMASK; // RULE1
				`PDSC_OFS_NM_SRC:    nm_src_reg    <= reg_wdata;
				`PDSC_OFS_PRESCALE:  prescale_reg  <= reg_wdata;
				`PDSC_OFS_MULT_HIGH: mult_high_reg <= reg_wdata;
				`PDSC_OFS_FRAC_LOW:  frac_low_reg  <= reg_wdata;
				default: ;
			endcase
		end
	end

	// read data one cycle after the strobe; unmapped offsets read zero, hit low
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reg_rdata  <= 8'h00;
			reg_rvalid <= 1'b0;
			reg_hit    <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			reg_hit    <= 1'b0;
			reg_rdata  <= 8'h00;
			if (reg_rd) begin
				reg_hit <= 1'b1;
				unique case (reg_addr)
					`PDSC_OFS_SEC_SRC:   reg_rdata <= sec_src_reg;
					`PDSC_OFS_NM_SRC:    reg_rdata <= nm_src_reg;
					`PDSC_OFS_PRESCALE:  reg_rdata <= prescale_reg;
					`PDSC_OFS_MULT_HIGH: reg_rdata <= mult_high_reg;
					`PDSC_OFS_FRAC_LOW:  reg_rdata <= frac_low_reg;
					default:             reg_hit   <= 1'b0;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// programmed fields
	// ----------------------------------------------------------------
	pdsc_src_sel_t sel_now;
	pdsc_pll_cfg_t prog_cfg;
	pdsc_pll_cfg_t eff_cfg;

	always_comb begin
		sel_now.second_port_bitdiv_source = sec_src_reg[`PDSC_SEC_SRC_HI:`PDSC_SEC_SRC_LO]; // RULE1
		sel_now.digital_nm_source         = nm_src_reg[`PDSC_DIG_NM_HI:`PDSC_DIG_NM_LO];    // RULE2
		sel_now.analog_nm_source          = nm_src_reg[`PDSC_ANA_NM_HI:`PDSC_ANA_NM_LO];    // RULE3
	end

	always_comb begin
		prog_cfg.p_div  = (prescale_reg == 8'h00) ? `PDSC_PRESCALE_ZERO : {1'b0, prescale_reg}; // RULE4
		prog_cfg.j_mult = {mult_high_reg[`PDSC_JMUL_TOP_BIT], pll_integer_mult_low};          // RULE6
		prog_cfg.halve  = mult_high_reg[`PDSC_HALVE_BIT];                                     // RULE7
		prog_cfg.d_frac = {mult_high_reg[`PDSC_FRAC_TOP_HI:`PDSC_FRAC_TOP_LO], frac_low_reg}; // RULE8
	end

	// halving is not an auto-derived setting and stays programmed
	always_comb begin
		eff_cfg = prog_cfg;
		if (auto_detect_en) begin // RULE5
			eff_cfg.p_div  = auto_cfg.p_div;
			eff_cfg.j_mult = auto_cfg.j_mult;
			eff_cfg.d_frac = auto_cfg.d_frac;
		end
	end

	logic cfg_bad;
	// a reserved multiplier or fraction yields no frequency
	assign cfg_bad = (eff_cfg.j_mult == 9'h000) || (eff_cfg.d_frac > `PDSC_FRAC_MAX); // RULE11

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			src_sel   <= '0;
			pll_cfg   <= '0;
			cfg_error <= 1'b0;
		end else begin
			src_sel   <= sel_now;
			pll_cfg   <= eff_cfg;
			cfg_error <= cfg_bad;
		end
	end

	// ----------------------------------------------------------------
	// clock source selection
	// ----------------------------------------------------------------
	logic       pll_s;
	logic       prim_s;
	logic       sec_s;
	logic       control_port_clock_s;
	logic       osc_s;
	logic       dsp_s;
	logic [7:0] sec_src_vec;
	logic [3:0] dig_src_vec;
	logic [3:0] ana_src_vec;

	// sampled levels only: a tap for monitoring and frequency checks, not a clock tree
	pdsc_sync #(
		.W(6)
	) u_sync (
		.clk      (clk),
		.rst      (rst),
		.async_in ({dsp_clk, osc_clk, control_port_clock, secondary_bitclk, primary_bitclk, pll_out_clk}),
		.sync_out ({dsp_s, osc_s, control_port_clock_s, sec_s, prim_s, pll_s})
	);

	assign sec_src_vec = {1'b0, 1'b0, dsp_s, osc_s, control_port_clock_s, 1'b0, prim_s, pll_s}; // RULE1
	assign dig_src_vec = {osc_s, control_port_clock_s, sec_s, prim_s};                          // RULE2
	assign ana_src_vec = {prim_s, digital_nm_clk, pll_s, pll_s};                  // RULE3

	pdsc_src_mux #(
		.SW    (3),
		.VALID (`PDSC_SEC_SRC_VALID)
	) u_sec_mux (
		.clk          (clk),
		.rst          (rst),
		.src          (sec_src_vec),
		.sel          (sel_now.second_port_bitdiv_source),
		.out_reg      (second_port_bitdiv_clk),
		.reserved_reg (second_port_src_reserved)
	);

	pdsc_src_mux #(
		.SW    (2),
		.VALID (4'hF)
	) u_dig_mux (
		.clk          (clk),
		.rst          (rst),
		.src          (dig_src_vec),
		.sel          (sel_now.digital_nm_source),
		.out_reg      (digital_nm_clk),
		.reserved_reg ()
	);

	pdsc_src_mux #(
		.SW    (2),
		.VALID (4'hF)
	) u_ana_mux (
		.clk          (clk),
		.rst          (rst),
		.src          (ana_src_vec),
		.sel          (sel_now.analog_nm_source),
		.out_reg      (analog_nm_clk),
		.reserved_reg ()
	);

	// ----------------------------------------------------------------
	// output frequency engine
	// ----------------------------------------------------------------
	// serial shift-add then restoring divide: slow, but tiny next to two wide multipliers
	pdsc_state_t   state_reg;
	logic [FW-1:0] snap_freq_reg;
	pdsc_pll_cfg_t snap_cfg_reg;
	logic [MW-1:0] mplier_reg;
	logic [NW-1:0] mcand_reg;
	logic [NW-1:0] acc_reg;
	logic [DW:0]   rem_reg;
	logic [DW-1:0] den_reg;
	logic [CW-1:0] cnt_reg;
	logic          snap_bad_reg;
	logic          changed;
	logic [MW-1:0] mult_op;
	logic [DW-1:0] den_op;
	logic [DW:0]   rem_sh;

	assign changed = (ref_freq_hz != snap_freq_reg) || (eff_cfg != snap_cfg_reg);
	assign mult_op = MW'(eff_cfg.j_mult) * MW'(`PDSC_FRAC_SCALE) + MW'(eff_cfg.d_frac); // RULE12
	assign den_op  = DW'(eff_cfg.p_div) * DW'(`PDSC_FRAC_SCALE);                        // RULE12
	assign rem_sh  = {rem_reg[DW-1:0], acc_reg[NW-1]};

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg     <= PDSC_ST_IDLE;
			snap_freq_reg <= '0;
			snap_cfg_reg  <= '0;
			snap_bad_reg  <= 1'b0;
			mplier_reg    <= '0;
			mcand_reg     <= '0;
			acc_reg       <= '0;
			rem_reg       <= '0;
			den_reg       <= '0;
			cnt_reg       <= '0;
		end else if (changed) begin
			// any change restarts, so a stale result never completes
			state_reg     <= PDSC_ST_MUL;
			snap_freq_reg <= ref_freq_hz;
			snap_cfg_reg  <= eff_cfg;
			snap_bad_reg  <= cfg_bad;
			mplier_reg    <= mult_op;
			mcand_reg     <= NW'(ref_freq_hz);
			acc_reg       <= '0;
			den_reg       <= den_op;
			cnt_reg       <= '0;
		end else begin
			unique case (state_reg)
				PDSC_ST_IDLE: ;
				PDSC_ST_MUL: begin
					if (mplier_reg[0]) begin
						acc_reg <= acc_reg + mcand_reg;
					end
					mplier_reg <= mplier_reg >> 1;
					mcand_reg  <= mcand_reg << 1;
					cnt_reg    <= cnt_reg + 1'b1;
					if (cnt_reg == CW'(MW - 1)) begin
						state_reg <= PDSC_ST_DIV;
						cnt_reg   <= '0;
						rem_reg   <= '0;
					end
				end
				PDSC_ST_DIV: begin
					if (rem_sh >= {1'b0, den_reg}) begin
						rem_reg <= rem_sh - {1'b0, den_reg};
						acc_reg <= {acc_reg[NW-2:0], 1'b1};
					end else begin
						rem_reg <= rem_sh;
						acc_reg <= {acc_reg[NW-2:0], 1'b0};
					end
					cnt_reg <= cnt_reg + 1'b1;
					if (cnt_reg == CW'(NW - 1)) begin
						state_reg <= PDSC_ST_DONE;
					end
				end
				PDSC_ST_DONE: state_reg <= PDSC_ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pll_freq_hz <= '0;
			freq_valid  <= 1'b0;
		end else if (changed) begin
			freq_valid <= 1'b0;
		end else if (state_reg == PDSC_ST_DONE) begin
			if (snap_bad_reg) begin // RULE11
				pll_freq_hz <= '0;
				freq_valid  <= 1'b0;
			end else begin
				// saturate rather than wrap on an absurd setting
				pll_freq_hz <= (|acc_reg[NW-1:OW]) ? '1 : acc_reg[OW-1:0];
				freq_valid  <= 1'b1;
			end
		end
	end

endmodule

`default_nettype wire

// *** verif/pdsc_top_chk.sv ***
// pdsc_top_chk: concurrent checks on the ports of pdsc_top.
// assumes one clock domain; attached to every pdsc_top by the bind below.
`timescale 1ns/100ps
`default_nettype none
module pdsc_top_chk
	import pdsc_pkg::*;
#(
	parameter int FW = 28,
	parameter int OW = 32
) (
	input wire logic          clk,
	input wire logic          rst,
	input wire logic          reg_wr,
	input wire logic [7:0]    reg_addr,
	input wire logic [7:0]    reg_wdata,
	input wire logic [7:0]    pll_integer_mult_low,
	input wire logic          auto_detect_en,
	input wire pdsc_pll_cfg_t auto_cfg,
	input wire logic          primary_bitclk,
	input wire logic          osc_clk,
	input wire logic [FW-1:0] ref_freq_hz,
	input wire pdsc_src_sel_t src_sel,
	input wire pdsc_pll_cfg_t pll_cfg,
	input wire logic          digital_nm_clk,
	input wire logic          analog_nm_clk,
	input wire logic          second_port_src_reserved,
	input wire logic          cfg_error,
	input wire logic [OW-1:0] pll_freq_hz,
	input wire logic          freq_valid
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// ----------------------------------------------------------------
	// helper logic
	// ----------------------------------------------------------------
	pdsc_pll_cfg_t ac_q;
	logic [63:0]   num;
	logic [63:0]   den;
	logic [63:0]   quo;
	logic [OW-1:0] fexp;
	logic          bad;
	always_ff @(posedge clk) begin
		ac_q <= auto_cfg;
	end
	// 64 bits hold the widest product without wrapping
	assign num = 64'(ref_freq_hz) * (64'(pll_cfg.j_mult) * 10000 + 64'(pll_cfg.d_frac));
	assign den = 64'(pll_cfg.p_div) * 10000;
	assign quo = (den == '0) ? '0 : num / den;
	assign fexp = ((quo >> OW) != '0) ? '1 : quo[OW-1:0];
	assign bad = (pll_cfg.j_mult == 9'h000) || (pll_cfg.d_frac > 14'h270F);
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	sequence s_osc_held; (src_sel.digital_nm_source == 2'h3 && $stable(osc_clk))[*4]; endsequence
	sequence s_pri_held; (src_sel.analog_nm_source == 2'h3 && $stable(primary_bitclk))[*4]; endsequence
	property p_dig_route; s_osc_held |-> digital_nm_clk == osc_clk; endproperty
	a_dig_route: assert property (p_dig_route) else $error("digital nm clock off its source");
	property p_ana_route; s_pri_held |-> analog_nm_clk == primary_bitclk; endproperty
	a_ana_route: assert property (p_ana_route) else $error("analog nm clock off its source");
	property p_sec_flag; $stable(src_sel.second_port_bitdiv_source)[*3] |->
		second_port_src_reserved == (src_sel.second_port_bitdiv_source inside {3'h2, 3'h6, 3'h7}); endproperty
	a_sec_flag: assert property (p_sec_flag) else $error("reserved source flag wrong");
	// a write lands in the register, then pll_cfg one edge later: auto must stay off over both
	sequence s_manual_wr(ofs);
		reg_wr && reg_addr == ofs && !auto_detect_en ##1 !auto_detect_en; endsequence
	property p_prescale; s_manual_wr(8'h35) |=>
		pll_cfg.p_div == (($past(reg_wdata, 2) == 8'h00) ? 9'h100 : {1'b0, $past(reg_wdata, 2)}); endproperty
	a_prescale: assert property (p_prescale) else $error("prescale value wrong");
	property p_jtop; s_manual_wr(8'h36) |=>
		pll_cfg.j_mult == {$past(reg_wdata[7], 2), $past(pll_integer_mult_low)}; endproperty
	a_jtop: assert property (p_jtop) else $error("integer multiplier wrong");
	property p_dlow; s_manual_wr(8'h37) |=> pll_cfg.d_frac[7:0] == $past(reg_wdata, 2); endproperty
	a_dlow: assert property (p_dlow) else $error("fraction low byte wrong");
	property p_auto; auto_detect_en |=> {pll_cfg.p_div, pll_cfg.j_mult, pll_cfg.d_frac} ==
		{ac_q.p_div, ac_q.j_mult, ac_q.d_frac}; endproperty
	a_auto: assert property (p_auto) else $error("auto settings not applied");
	property p_cfg_err; $stable(bad)[*3] |-> cfg_error == bad; endproperty
	a_cfg_err: assert property (p_cfg_err) else $error("config error flag wrong");
	property p_freq; freq_valid && $stable(pll_cfg) && $stable(ref_freq_hz) |-> pll_freq_hz == fexp; endproperty
	a_freq: assert property (p_freq) else $error("output frequency wrong");
endmodule
bind pdsc_top pdsc_top_chk #(.FW(FW), .OW(OW)) u_chk (.*);
`default_nettype wire

// *** verif/pdsc_top_test.sv ***
// pdsc_top_test: register, routing and frequency tests of pdsc_top.
// assumes the checker binds itself; inputs change at falling edges.
`timescale 1ns/100ps
`default_nettype none
module pdsc_top_test
	import pdsc_pkg::*;
;
	logic          clk, rst, reg_wr, reg_rd, reg_rvalid, reg_hit, auto_en;
	logic [7:0]    reg_addr, reg_wdata, reg_rdata, mult_low;
	logic [5:0]    pins; // pll, primary, secondary, control, osc, dsp
	pdsc_pll_cfg_t auto_cfg, pll_cfg;
	pdsc_src_sel_t src_sel;
	logic          sp_clk, dn_clk, an_clk, sp_res, cfg_error, freq_valid;
	logic [27:0]   ref_hz;
	logic [31:0]   freq_hz;
	int            mismatches, total_checks;
	pdsc_top dut (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_hit(reg_hit),
		.pll_integer_mult_low(mult_low), .auto_detect_en(auto_en), .auto_cfg(auto_cfg),
		.pll_out_clk(pins[0]), .primary_bitclk(pins[1]), .secondary_bitclk(pins[2]),
		.control_port_clock(pins[3]), .osc_clk(pins[4]), .dsp_clk(pins[5]), .ref_freq_hz(ref_hz),
		.src_sel(src_sel), .pll_cfg(pll_cfg), .second_port_bitdiv_clk(sp_clk), .digital_nm_clk(dn_clk),
		.analog_nm_clk(an_clk), .second_port_src_reserved(sp_res), .cfg_error(cfg_error),
		.pll_freq_hz(freq_hz), .freq_valid(freq_valid));
	initial begin
		clk = 0;
		forever #25 clk = ~clk;
	end
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_wr = 1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk);
		reg_wr = 0;
		// idle edge: a following call never re-raises the strobe in the same step
		@(negedge clk);
	endtask
	// read data stands only in the cycle after the read edge
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic hit);
		reg_rd = 1;
		reg_addr = a;
		@(negedge clk);
		reg_rd = 0;
		check({reg_rvalid, reg_hit, reg_rdata}, {1'b1, hit, exp});
		@(negedge clk);
	endtask
	task automatic wait_valid();
		int n;
		n = 0;
		while (freq_valid !== 1'b1 && n < 120) begin
			@(negedge clk);
			n++;
		end
		check(n < 120, 1'b1);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		#(5000 * 50);
		mismatches++;
		print_verdict();
	end
	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		logic [7:0] rv [5];
		rv = '{8'h00, 8'h10, 8'h01, 8'h00, 8'h00};
		{reg_wr, reg_rd, auto_en, reg_addr, reg_wdata} = '0;
		rst = 1;
		mult_low = 8'h08;
		pins = 6'h00;
		ref_hz = 28'd1000000;
		auto_cfg = '{p_div: 9'h003, j_mult: 9'h005, d_frac: 14'h0007, halve: 1'b0};
		repeat (8) @(negedge clk);
		rst = 0;
		for (int i = 0; i < 5; i++) rd(8'(8'h33 + i), rv[i], 1'b1);
		rd(8'h38, 8'h00, 1'b0);
		$display("test reset values done");
		for (int p = 0; p < 2; p++) begin
			pins = p ? 6'h2A : 6'h15;
			for (int c = 0; c < 8; c++) begin
				wr(8'h33, {1'b0, c[2:0], 4'h0});
				repeat (5) @(negedge clk);
				check(src_sel.second_port_bitdiv_source, c);
				check(sp_res, c inside {2, 6, 7});
				check(sp_clk, (c inside {2, 6, 7}) ? 1'b0 : pins[c]);
			end
			// digital code runs opposite so that analog code 2 sees secondary
			for (int i = 0; i < 4; i++) begin
				wr(8'h34, {2'(3 - i), i[1:0], 4'h0});
				repeat (6) @(negedge clk);
				check(dn_clk, pins[4 - i]);
				check(an_clk, (i < 2) ? pins[0] : pins[(i == 2) ? 2 : 1]);
				check(src_sel.digital_nm_source, 3 - i);
				check(src_sel.analog_nm_source, i);
			end
		end
		$display("test source routing done");
		wr(8'h35, 8'h00);
		check(pll_cfg.p_div, 9'h100);
		rd(8'h35, 8'h00, 1'b1);
		wr(8'h35, 8'hFF);
		check(pll_cfg.p_div, 9'h0FF);
		wr(8'h35, 8'h02);
		wr(8'h36, 8'hC5);
		check(pll_cfg.j_mult, 9'h108);
		check(pll_cfg.halve, 1'b1);
		wr(8'h37, 8'h0F);
		check(pll_cfg.d_frac, 14'h050F);
		rd(8'h36, 8'hC5, 1'b1);
		wait_valid();
		check(freq_hz, 64'(ref_hz) * (264 * 10000 + 1295) / (2 * 10000));
		$display("test multipliers done");
		wr(8'h36, 8'hE7);
		repeat (3) @(negedge clk);
		check(cfg_error, 1'b0);
		wr(8'h37, 8'h10);
		repeat (3) @(negedge clk);
		check({cfg_error, freq_valid}, 2'b10);
		wr(8'h37, 8'h0F);
		mult_low = 8'h00;
		wr(8'h36, 8'h67);
		repeat (3) @(negedge clk);
		check({cfg_error, freq_valid}, 2'b10);
		$display("test config errors done");
		auto_en = 1;
		repeat (2) @(negedge clk);
		check(pll_cfg, {9'h003, 9'h005, 14'h0007, 1'b1});
		wait_valid();
		check(freq_hz, 64'(ref_hz) * (5 * 10000 + 7) / (3 * 10000));
		auto_en = 0;
		mult_low = 8'h08;
		$display("test auto detection done");
		print_verdict();
	end
endmodule
`default_nettype wire
